// ===== rtl/sonet_rx_defect_monitor.sv
// Receive defect monitor: signal, frame, pointer and cell-delineation loss,
// path defect indication in G1 and line block-error count in Z2.
// Assumes strobes from a framer, pointer reader, header checker and parity checkers,
// all synchronous to clk.
//
// Operation
// - Signal loss within 100us of 2.3us zeros
// - Zeros means no transitions or no light
// - Leave signal loss after two clean frame patterns
// - Out-of-frame after four errored framing patterns
// - Frame loss after 3 ms out-of-frame
// - Clear frame loss after 3 ms in-frame
// - Pointer loss after 8-10 invalid or NEW_DATA_FLAG frames
// - New-data flag is pointer word bits 1-4
// - Clear pointer loss after three good frames
// - Cell loss after seven bad header checks
// - Leave cell loss after one plus six good
// - Set G1 bit 5 within 250us
// - Hold bit while defects, clear within 250us
// - Z2 count legal range 0 to 8N
// - Z2 third byte carries B2 mismatches
// - Same behaviour at the faster line rate
// - Line parity covers previous frame, before scrambling
// - G1 bits 1-4 carry B3 mismatches
`timescale 1ns/100ps
module sonet_rx_defect_monitor
    import defect_pkg::*;
#(
    parameter int FRAME_LOSS_CYCLES = FRAME_LOSS_CYC,
    parameter int RDI_CYCLES        = RDI_MAX_CYC
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Configuration
    input  wire logic             optical_sel,
    input  wire logic             rate_sts12,
    input  wire logic [3:0]       ptr_loss_runs,
    // Line sampling
    input  wire logic             line_sample,
    input  wire logic             light_present,
    // Framer events
    input  wire logic             frame_strobe,
    input  wire logic             frame_pattern_ok,
    // Pointer events, one per frame
    input  wire logic             ptr_strobe,
    input  wire logic [15:0]      ptr_word,
    input  wire logic             ptr_valid,
    input  wire logic             ptr_concat,
    // Cell header check events
    input  wire logic             hdr_strobe,
    input  wire logic             hdr_ok,
    // Alarm indications detected upstream
    input  wire logic             line_ais,
    input  wire logic             path_ais,
    // Parity mismatch counts from the checkers
    input  wire logic             b2_strobe,
    input  wire logic [7:0]       b2_mismatch,
    input  wire logic             b3_strobe,
    input  wire logic [3:0]       b3_mismatch,
    // Sticky clear, one bit per defect
    input  wire logic [3:0]       change_clear,
    // Defect flags
    output logic                  signal_loss_state,
    output logic                  frame_loss_state,
    output logic                  out_of_frame,
    output logic                  pointer_loss_state,
    output logic                  cell_delineation_loss_state,
    output logic [3:0]            change_sticky,
    // Outgoing overhead
    output logic [7:0]            g1_byte,
    output logic [7:0]            z2_third_byte,
    output logic                  remote_defect_indication
);
    // Parameter checks
    initial begin
        if (FRAME_LOSS_CYCLES < 1 || RDI_CYCLES < 1) begin
            $error("persistence counts must be at least one cycle");
        end
    end

    // Cell delineation states
    typedef enum logic [1:0] {CELL_HUNT, CELL_PRESYNC, CELL_SYNC} cell_state_t;

    // Counter widths sized to the longest persistence
    localparam int FL_W  = $clog2(FRAME_LOSS_CYCLES + 1);
    localparam int RD_W  = $clog2(RDI_CYCLES + 1);
    localparam int ZR_W  = $clog2(ZEROS_MIN_CYC + 1);

    logic signal_loss_r;
    logic signal_loss_nxt;
    logic frame_loss_r;
    logic oof_r;
    logic oof_nxt;
    logic ptr_loss_r;
    logic ptr_loss_nxt;
    logic cell_loss_r;
    cell_state_t cell_r;
    cell_state_t cell_nxt;
    logic [2:0] oof_errs_r;
    logic [2:0] oof_errs_nxt;
    logic [1:0] clean_frames_r;
    logic [1:0] clean_frames_nxt;
    logic [3:0] ptr_bad_r;
    logic [3:0] ptr_ndf_r;
    logic [1:0] ptr_good_r;
    logic [2:0] hdr_run_r;
    logic [2:0] hdr_run_nxt;
    logic       prev_sample_r;
    logic [3:0] flags_prev_r;
    logic [3:0] sticky_r;
    logic       rdi_r;
    logic [3:0] far_end_block_error_count_r;
    logic [7:0] z2_r;

    // Zeros detection: electrical looks for transitions, optical for light
    wire  line_activity = optical_sel ? light_present : (line_sample != prev_sample_r);
    wire  zeros_found;
    wire  frame_loss_set;
    wire  frame_loss_clr;
    wire  defect_any;
    wire  rdi_set_due;
    wire  rdi_clr_due;

    // Zeros stretch of at least the minimum time
    persist_counter #(.WIDTH(ZR_W)) zeros_run (
        .clk     (clk),
        .reset   (reset),
        .step    (1'b1),
        .restart (line_activity),
        .limit   (ZR_W'(ZEROS_MIN_CYC)),
        .reached (zeros_found)
    );

    // Out-of-frame persistence
    persist_counter #(.WIDTH(FL_W)) oof_run (
        .clk     (clk),
        .reset   (reset),
        .step    (oof_r),
        .restart (!oof_r),
        .limit   (FL_W'(FRAME_LOSS_CYCLES)),
        .reached (frame_loss_set)
    );

    // In-frame persistence
    persist_counter #(.WIDTH(FL_W)) inframe_run (
        .clk     (clk),
        .reset   (reset),
        .step    (!oof_r),
        .restart (oof_r),
        .limit   (FL_W'(FRAME_LOSS_CYCLES)),
        .reached (frame_loss_clr)
    );

    // Defect indication set and release delays, shorter than 250us
    assign defect_any = signal_loss_r | frame_loss_r | ptr_loss_r | cell_loss_r
                      | line_ais | path_ais;

    persist_counter #(.WIDTH(RD_W)) rdi_on_run (
        .clk     (clk),
        .reset   (reset),
        .step    (defect_any),
        .restart (!defect_any),
        .limit   (RD_W'(1)),
        .reached (rdi_set_due)
    );

    persist_counter #(.WIDTH(RD_W)) rdi_off_run (
        .clk     (clk),
        .reset   (reset),
        .step    (!defect_any),
        .restart (defect_any),
        .limit   (RD_W'(1)),
        .reached (rdi_clr_due)
    );

    // Signal loss: set on zeros, cleared after two clean frame patterns
    always_comb begin
        signal_loss_nxt  = signal_loss_r;
        clean_frames_nxt = clean_frames_r;
        if (zeros_found) begin
            signal_loss_nxt  = 1'b1;
            clean_frames_nxt = '0;
        end else if (signal_loss_r && frame_strobe) begin
            if (!frame_pattern_ok) begin
                clean_frames_nxt = '0;
            end else if (clean_frames_r + 2'd1 >= 2'(SIGNAL_CLEAR_COUNT)) begin
                signal_loss_nxt  = 1'b0;
                clean_frames_nxt = '0;
            end else begin
                clean_frames_nxt = clean_frames_r + 2'd1;
            end
        end
    end

    // Out-of-frame on four consecutive errored patterns, cleared by a good one
    always_comb begin
        oof_nxt      = oof_r;
        oof_errs_nxt = oof_errs_r;
        if (frame_strobe) begin
            if (frame_pattern_ok) begin
                oof_errs_nxt = '0;
                oof_nxt      = 1'b0;
            end else begin
                if (oof_errs_r < 3'(OOF_ERR_COUNT)) begin
                    oof_errs_nxt = oof_errs_r + 3'd1;
                end
                if (oof_errs_r + 3'd1 >= 3'(OOF_ERR_COUNT)) begin
                    oof_nxt = 1'b1;
                end
            end
        end
    end

    // Pointer checks; the flag nibble is the top of the word
    wire [3:0] ndf_bits   = ptr_word[NDF_MSB:NDF_LSB];
    wire       ndf_normal = (ndf_bits == NDF_NORMAL);
    wire       ptr_good   = ptr_concat | (ptr_valid & ndf_normal);
    wire [3:0] run_limit  = (ptr_loss_runs < 4'(PTR_LOSS_MIN) || ptr_loss_runs > 4'(PTR_LOSS_MAX))
                          ? 4'(PTR_LOSS_DEFAULT) : ptr_loss_runs;
    wire [3:0] bad_nxt    = (ptr_valid | ptr_concat) ? 4'd0
                          : ((ptr_bad_r < run_limit) ? ptr_bad_r + 4'd1 : ptr_bad_r);
    wire [3:0] ndf_nxt    = (ptr_valid & !ndf_normal)
                          ? ((ptr_ndf_r < run_limit) ? ptr_ndf_r + 4'd1 : ptr_ndf_r) : 4'd0;
    wire [1:0] good_nxt   = ptr_good ? ((ptr_good_r < 2'(PTR_CLEAR_COUNT)) ?
                            ptr_good_r + 2'd1 : ptr_good_r) : 2'd0;

    always_comb begin
        ptr_loss_nxt = ptr_loss_r;
        if (ptr_strobe) begin
            if (bad_nxt >= run_limit || ndf_nxt >= run_limit) begin
                ptr_loss_nxt = 1'b1;
            end else if (good_nxt >= 2'(PTR_CLEAR_COUNT)) begin
                ptr_loss_nxt = 1'b0;
            end
        end
    end

    // Cell delineation: hunt, presync, sync
    always_comb begin
        cell_nxt    = cell_r;
        hdr_run_nxt = hdr_run_r;
        if (hdr_strobe) begin
            case (cell_r)
                CELL_HUNT: begin
                    hdr_run_nxt = '0;
                    if (hdr_ok) begin
                        cell_nxt = CELL_PRESYNC;
                    end
                end
                CELL_PRESYNC: begin
                    if (!hdr_ok) begin
                        cell_nxt    = CELL_HUNT;
                        hdr_run_nxt = '0;
                    end else if (hdr_run_r + 3'd1 >= 3'(CELL_DELTA)) begin
                        cell_nxt    = CELL_SYNC;
                        hdr_run_nxt = '0;
                    end else begin
                        hdr_run_nxt = hdr_run_r + 3'd1;
                    end
                end
                CELL_SYNC: begin
                    if (hdr_ok) begin
                        hdr_run_nxt = '0;
                    end else if (hdr_run_r + 3'd1 >= 3'(CELL_ALPHA)) begin
                        cell_nxt    = CELL_HUNT;
                        hdr_run_nxt = '0;
                    end else begin
                        hdr_run_nxt = hdr_run_r + 3'd1;
                    end
                end
                default: begin
                    cell_nxt    = CELL_HUNT;
                    hdr_run_nxt = '0;
                end
            endcase
        end
    end

    // Line error count above the legal range for the rate is sent as zero
    wire [7:0] line_max = rate_sts12 ? 8'(8 * LINE_N_STS12) : 8'(8 * LINE_N_STS3);
    wire [7:0] z2_legal = (b2_mismatch > line_max) ? 8'h00 : b2_mismatch;

    // Sticky change bits; a change in the clear cycle still sets
    wire [3:0] flags_now = {cell_loss_r, ptr_loss_r, frame_loss_r, signal_loss_r};
    wire [3:0] sticky_nxt = (sticky_r & ~change_clear) | (flags_now ^ flags_prev_r);

    // Defect state registers
    always_ff @(posedge clk) begin
        if (reset) begin
            signal_loss_r  <= 1'b0;
            clean_frames_r <= '0;
            oof_r          <= 1'b0;
            oof_errs_r     <= '0;
            prev_sample_r  <= 1'b0;
        end else begin
            signal_loss_r  <= signal_loss_nxt;
            clean_frames_r <= clean_frames_nxt;
            oof_r          <= oof_nxt;
            oof_errs_r     <= oof_errs_nxt;
            prev_sample_r  <= line_sample;
        end
    end

    // Frame loss follows the two persistence windows
    always_ff @(posedge clk) begin
        if (reset) begin
            frame_loss_r <= 1'b0;
        end else if (frame_loss_set) begin
            frame_loss_r <= 1'b1;
        end else if (frame_loss_clr) begin
            frame_loss_r <= 1'b0;
        end
    end

    // Pointer counters only move on a pointer strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            ptr_loss_r <= 1'b0;
            ptr_bad_r  <= '0;
            ptr_ndf_r  <= '0;
            ptr_good_r <= '0;
        end else if (ptr_strobe) begin
            ptr_loss_r <= ptr_loss_nxt;
            ptr_bad_r  <= bad_nxt;
            ptr_ndf_r  <= ndf_nxt;
            ptr_good_r <= good_nxt;
        end
    end

    // Cell state, starts hunting but not in loss
    always_ff @(posedge clk) begin
        if (reset) begin
            cell_r      <= CELL_HUNT;
            hdr_run_r   <= '0;
            cell_loss_r <= 1'b0;
        end else begin
            cell_r      <= cell_nxt;
            hdr_run_r   <= hdr_run_nxt;
            cell_loss_r <= (cell_nxt != CELL_SYNC) && (cell_r != CELL_SYNC || cell_nxt == CELL_HUNT)
                           ? ((cell_r == CELL_SYNC) ? 1'b1 : cell_loss_r | (cell_nxt == CELL_HUNT
                              && cell_r == CELL_SYNC)) : 1'b0;
        end
    end

    // Sticky and indication registers
    always_ff @(posedge clk) begin
        if (reset) begin
            flags_prev_r <= '0;
            sticky_r     <= '0;
            rdi_r        <= 1'b0;
        end else begin
            flags_prev_r <= flags_now;
            sticky_r     <= sticky_nxt;
            if (rdi_set_due) begin
                rdi_r <= 1'b1;
            end else if (rdi_clr_due) begin
                rdi_r <= 1'b0;
            end
        end
    end

    // Outgoing overhead counts latched per parity result
    always_ff @(posedge clk) begin
        if (reset) begin
            far_end_block_error_count_r <= '0;
            z2_r   <= '0;
        end else begin
            if (b3_strobe) begin
                far_end_block_error_count_r <= b3_mismatch;
            end
            if (b2_strobe) begin
                z2_r <= z2_legal;
            end
        end
    end

    // Outputs straight from flip-flops
    assign signal_loss_state           = signal_loss_r;
    assign frame_loss_state            = frame_loss_r;
    assign out_of_frame                = oof_r;
    assign pointer_loss_state          = ptr_loss_r;
    assign cell_delineation_loss_state = cell_loss_r;
    assign change_sticky               = sticky_r;
    assign remote_defect_indication    = rdi_r;
    assign z2_third_byte               = z2_r;
    // Low three bits unused and sent as zero
    assign g1_byte = {far_end_block_error_count_r, rdi_r, 3'h0};
endmodule // sonet_rx_defect_monitor

// ===== rtl/defect_pkg.sv
// Constants shared by the receive defect monitor, its checker and its bench.
// Assumes a 50 MHz system clock; all line events arrive as one-cycle strobes.
package defect_pkg;
    localparam int CLK_MHZ            = 50;
    localparam int CLK_PERIOD_NS      = 20;
    // Signal-loss timing, in nanoseconds
    localparam int ZEROS_MIN_NS       = 2300;
    localparam int SIGNAL_LOSS_MAX_NS = 100000;
    // Least time rounds up to whole cycles
    localparam int ZEROS_MIN_CYC      = (ZEROS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Frame-loss persistence, in microseconds
    localparam int FRAME_LOSS_US      = 3000;
    localparam int FRAME_LOSS_CYC     = FRAME_LOSS_US * CLK_MHZ;
    // Defect indication response time, in microseconds
    localparam int RDI_MAX_US         = 250;
    localparam int RDI_MAX_CYC        = RDI_MAX_US * CLK_MHZ;
    // Framing and pointer counts
    localparam int OOF_ERR_COUNT      = 4;
    localparam int PTR_LOSS_DEFAULT   = 8;
    localparam int PTR_LOSS_MIN       = 8;
    localparam int PTR_LOSS_MAX       = 10;
    localparam int PTR_CLEAR_COUNT    = 3;
    localparam int SIGNAL_CLEAR_COUNT = 2;
    // Cell delineation counts
    localparam int CELL_ALPHA         = 7;
    localparam int CELL_DELTA         = 6;
    // Pointer word layout: new-data flag in bits 1..4 (the top nibble)
    localparam int NDF_MSB            = 15;
    localparam int NDF_LSB            = 12;
    localparam logic [3:0] NDF_NORMAL = 4'h6;
    // Path status byte layout, bit 1 is the msb
    localparam int G1_RDI_POS         = 3;
    // Line error count, N = 3 for the slower rate
    localparam int LINE_N_STS3        = 3;
    localparam int LINE_N_STS12       = 12;
    localparam int SUM_W              = 8;
endpackage : defect_pkg

// ===== rtl/persist_counter.sv
// Saturating run counter used for every persistence window in the monitor.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
module persist_counter #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             reset,
    // Run control
    input  wire logic             step,
    input  wire logic             restart,
    input  wire logic [WIDTH-1:0] limit,
    // Result
    output logic                  reached
);
    logic [WIDTH-1:0] count_r;
    logic [WIDTH-1:0] count_nxt;
    wire              at_limit = (count_r >= limit);

    // Restart wins over a step so a broken run never counts on
    assign count_nxt = restart ? '0 : ((step && !at_limit) ? count_r + 1'b1 : count_r);

    always_ff @(posedge clk) begin
        if (reset) begin
            count_r <= '0;
        end else begin
            count_r <= count_nxt;
        end
    end

    assign reached = at_limit;
endmodule // persist_counter

// ===== bench/defect_asserts.sv
// Checker for the receive defect monitor, watching its ports only.
// Assumes defect_pkg and a bind onto the top module.
`timescale 1ns/100ps
module defect_asserts
    import defect_pkg::*;
#(
    parameter int FRAME_LOSS_CYCLES = FRAME_LOSS_CYC,
    parameter int RDI_CYCLES        = RDI_MAX_CYC
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       reset,
    // Observed inputs
    input wire logic       optical_sel,
    input wire logic       rate_sts12,
    input wire logic       line_sample,
    input wire logic       light_present,
    input wire logic       frame_strobe,
    input wire logic       frame_pattern_ok,
    input wire logic       line_ais,
    input wire logic       path_ais,
    input wire logic       b2_strobe,
    input wire logic [7:0] b2_mismatch,
    input wire logic       b3_strobe,
    input wire logic [3:0] b3_mismatch,
    // Observed outputs
    input wire logic       signal_loss_state,
    input wire logic       frame_loss_state,
    input wire logic       out_of_frame,
    input wire logic       pointer_loss_state,
    input wire logic       cell_delineation_loss_state,
    input wire logic [3:0] change_sticky,
    input wire logic [7:0] g1_byte,
    input wire logic [7:0] z2_third_byte,
    input wire logic       remote_defect_indication
);
    logic       prev_r;
    logic [7:0] zeros_r;
    logic [2:0] bad_r;
    int         oof_r;
    // Any cause of the path defect bit
    wire defect = signal_loss_state | frame_loss_state | pointer_loss_state
        | cell_delineation_loss_state | line_ais | path_ais;
    wire       flat   = optical_sel ? !light_present : (line_sample == prev_r);
    wire [7:0] z2_max = rate_sts12 ? 8'h60 : 8'h18;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    // Run lengths: saturate so long runs never wrap back to short
    always_ff @(posedge clk) begin
        prev_r <= line_sample;
        if (reset || !flat)
            zeros_r <= 8'h00;
        else if (zeros_r != 8'hff)
            zeros_r <= zeros_r + 8'h01;
        if (reset || (frame_strobe && frame_pattern_ok))
            bad_r <= 3'h0;
        else if (frame_strobe && bad_r != 3'h4)
            bad_r <= bad_r + 3'h1;
        if (reset || !out_of_frame)
            oof_r <= 0;
        else if (oof_r < FRAME_LOSS_CYCLES + 8)
            oof_r <= oof_r + 1;
    end
    AST_LOS_SET: assert property (zeros_r >= ZEROS_MIN_CYC + 4 |-> signal_loss_state)
        else $error("signal loss missing after long zeros");
    AST_OOF_SET: assert property (frame_strobe && !frame_pattern_ok && bad_r >= 3'h3
        |=> out_of_frame) else $error("out of frame missing after four bad");
    AST_OOF_CLEAR: assert property (frame_strobe && frame_pattern_ok |=> !out_of_frame)
        else $error("out of frame kept after good pattern");
    AST_LOF_SET: assert property (oof_r == FRAME_LOSS_CYCLES + 3 |-> frame_loss_state)
        else $error("frame loss missing after persistence");
    AST_RDI_SET: assert property (defect [*4] |-> remote_defect_indication)
        else $error("defect indication missing");
    AST_RDI_CLEAR: assert property (!defect [*4] |-> !remote_defect_indication)
        else $error("defect indication kept");
    AST_G1_RDI: assert property (g1_byte[G1_RDI_POS] == remote_defect_indication
        && g1_byte[2:0] == 3'h0) else $error("path status bit wrong");
    AST_G1_FAR_END_BLOCK_ERROR_COUNT: assert property (b3_strobe |=> g1_byte[7:4] == $past(b3_mismatch))
        else $error("path error count wrong");
    AST_Z2_COUNT: assert property (b2_strobe && b2_mismatch <= z2_max
        |=> z2_third_byte == $past(b2_mismatch)) else $error("line count wrong");
    AST_Z2_ILLEGAL: assert property (b2_strobe && b2_mismatch > z2_max
        |=> z2_third_byte == 8'h00) else $error("illegal line count passed");
    AST_STICKY: assert property ($rose(signal_loss_state) |-> ##[0:1] change_sticky[0])
        else $error("sticky change missing");
    COV_LOS: cover property ($rose(signal_loss_state));
    COV_LOF: cover property ($rose(frame_loss_state));
    COV_LOP: cover property ($rose(pointer_loss_state));
    COV_LOC: cover property ($rose(cell_delineation_loss_state));
endmodule // defect_asserts

bind sonet_rx_defect_monitor defect_asserts #(
    .FRAME_LOSS_CYCLES(FRAME_LOSS_CYCLES),
    .RDI_CYCLES(RDI_CYCLES)
) u_asserts (.*);

// ===== bench/line_peer.sv
// Peer line model: toggling line, light and periodic framing patterns.
// Assumes the bench sets optical, zeros and bad just after a clock edge.
`timescale 1ns/100ps
module line_peer #(
    parameter int FRAME_GAP = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Control from the bench
    input wire logic optical,
    input wire logic zeros,
    input wire logic bad,
    // Line side
    output logic     line_sample,
    output logic     light_present,
    output logic     frame_strobe,
    output logic     frame_pattern_ok
);
    int cnt_r;
    // Only the medium in use goes quiet, so the wrong source is caught
    always_ff @(posedge clk) begin
        cnt_r <= (reset || cnt_r == FRAME_GAP - 1) ? 0 : cnt_r + 1;
        line_sample <= !reset && !(zeros && !optical) && !line_sample;
        light_present <= !(zeros && optical);
        frame_strobe <= !reset && !zeros && cnt_r == 0;
        frame_pattern_ok <= !bad;
    end
endmodule // line_peer

// ===== bench/sonet_rx_defect_monitor_tb.sv
// Bench for the receive defect monitor; each scenario task judges flags.
// Assumes line_peer on the line side and a 50 MHz clock.
`timescale 1ns/100ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin failures++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module sonet_rx_defect_monitor_tb;
    import defect_pkg::*;
    localparam int FL = 50;
    logic clk, reset, optical_sel, rate_sts12, zeros, bad;
    logic line_sample, light_present, frame_strobe, frame_pattern_ok;
    logic ptr_strobe, ptr_valid, ptr_concat, hdr_strobe, hdr_ok;
    logic line_ais, path_ais, b2_strobe, b3_strobe;
    logic [3:0] ptr_loss_runs, b3_mismatch, change_clear, change_sticky;
    logic [15:0] ptr_word;
    logic [7:0] b2_mismatch, g1_byte, z2_third_byte;
    logic signal_loss_state, frame_loss_state, out_of_frame, pointer_loss_state;
    logic cell_delineation_loss_state, remote_defect_indication;
    int failures = 0;
    int comparisons = 0;
    // Shortened persistence keeps the run brief
    sonet_rx_defect_monitor #(.FRAME_LOSS_CYCLES(FL)) dut (.*);
    line_peer peer (.clk, .reset, .optical(optical_sel), .zeros, .bad,
        .line_sample, .light_present, .frame_strobe, .frame_pattern_ok);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic step(int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic final_report();
        $display("failures=%0d comparisons=%0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Bounded wait for a pattern, then let the flags settle
    task automatic wait_frame();
        int i;
        i = 0;
        while (frame_strobe !== 1'b1 && i < 64) begin
            step();
            i++;
        end
        if (i == 64) begin
            failures++;
            final_report();
        end
        step(2);
    endtask
    // Flat line, then dark light; each ended by two clean patterns
    task automatic t_signal_loss();
        for (int m = 0; m < 2; m++) begin
            optical_sel = m[0];
            zeros = 1'b1;
            step(ZEROS_MIN_CYC + 8);
            `CHK(signal_loss_state, 1'b1)
            `CHK(change_sticky[0], 1'b1)
            `CHK(g1_byte[G1_RDI_POS], 1'b1)
            zeros = 1'b0;
            step(2);
            wait_frame();
            `CHK(signal_loss_state, 1'b1)
            wait_frame();
            `CHK(signal_loss_state, 1'b0)
            step(4);
            `CHK(remote_defect_indication, 1'b0)
            change_clear = 4'hf;
            step();
            change_clear = 4'h0;
            step();
            `CHK(change_sticky, 4'h0)
        end
    endtask
    // Four bad patterns, persistence, then recovery in-frame
    task automatic t_frame();
        bad = 1'b1;
        step();
        repeat (3) wait_frame();
        `CHK(out_of_frame, 1'b0)
        wait_frame();
        `CHK(out_of_frame, 1'b1)
        `CHK(frame_loss_state, 1'b0)
        step(FL + 4);
        `CHK(frame_loss_state, 1'b1)
        bad = 1'b0;
        step();
        wait_frame();
        `CHK(out_of_frame, 1'b0)
        step(FL + 4);
        `CHK(frame_loss_state, 1'b0)
    endtask
    // Strobe stays up between calls so frames arrive back to back
    task automatic ptr(logic v, logic c, logic [3:0] f, int n);
        repeat (n) begin
            ptr_strobe = 1'b1;
            ptr_valid = v;
            ptr_concat = c;
            ptr_word = {f, 12'h3a5};
            step();
        end
    endtask
    // Invalid and new-data runs at each length, then three good frames
    task automatic t_pointer();
        for (int r = 8; r <= 10; r++) begin
            ptr_loss_runs = r[3:0];
            ptr(1'b0, 1'b0, 4'h6, r - 1);
            `CHK(pointer_loss_state, 1'b0)
            ptr(1'b0, 1'b0, 4'h6, 1);
            `CHK(pointer_loss_state, 1'b1)
            ptr(1'b1, 1'b0, 4'h6, 2);
            `CHK(pointer_loss_state, 1'b1)
            ptr(1'b0, 1'b1, 4'h9, 1);
            `CHK(pointer_loss_state, 1'b0)
            ptr(1'b1, 1'b0, 4'h9, r - 1);
            `CHK(pointer_loss_state, 1'b0)
            ptr(1'b1, 1'b0, 4'h9, 1);
            `CHK(pointer_loss_state, 1'b1)
            ptr(1'b1, 1'b0, 4'h6, 3);
            `CHK(pointer_loss_state, 1'b0)
        end
        ptr_strobe = 1'b0;
        step();
    endtask
    task automatic hdr(logic ok, int n);
        repeat (n) begin
            hdr_strobe = 1'b1;
            hdr_ok = ok;
            step();
        end
    endtask
    // Reach sync, lose it after seven bad, regain after one plus six good
    task automatic t_cell();
        hdr(1'b1, 7);
        hdr(1'b0, 6);
        `CHK(cell_delineation_loss_state, 1'b0)
        hdr(1'b0, 1);
        `CHK(cell_delineation_loss_state, 1'b1)
        hdr(1'b1, 6);
        `CHK(cell_delineation_loss_state, 1'b1)
        hdr(1'b1, 1);
        `CHK(cell_delineation_loss_state, 1'b0)
        hdr_strobe = 1'b0;
        step();
    endtask
    // Line counts at both rates, path counts, then each alarm input
    task automatic t_overhead();
        logic [7:0] b2v [6] = '{8'h00, 8'h18, 8'h19, 8'hff, 8'h60, 8'h61};
        logic [7:0] b2e [6] = '{8'h00, 8'h18, 8'h00, 8'h00, 8'h60, 8'h00};
        for (int i = 0; i < 6; i++) begin
            rate_sts12 = (i >= 4);
            b2_strobe = 1'b1;
            b2_mismatch = b2v[i];
            b3_strobe = 1'b1;
            b3_mismatch = i[3:0] + 4'h3;
            step();
            `CHK(z2_third_byte, b2e[i])
            `CHK(g1_byte[7:4], i[3:0] + 4'h3)
        end
        {b2_strobe, b3_strobe} = 2'b00;
        for (int a = 0; a < 2; a++) begin
            {line_ais, path_ais} = a[0] ? 2'b01 : 2'b10;
            step(4);
            `CHK(remote_defect_indication, 1'b1)
            {line_ais, path_ais} = 2'b00;
            step(4);
            `CHK(g1_byte[G1_RDI_POS], 1'b0)
        end
    endtask
    initial begin
        {reset, optical_sel, rate_sts12, zeros, bad} = 5'h10;
        {ptr_strobe, ptr_valid, ptr_concat, hdr_strobe, hdr_ok} = 5'h00;
        {line_ais, path_ais, b2_strobe, b3_strobe} = 4'h0;
        ptr_loss_runs = 4'h8;
        ptr_word = 16'h0000;
        b2_mismatch = 8'h00;
        b3_mismatch = 4'h0;
        change_clear = 4'h0;
        step(12);
        reset = 1'b0;
        step(2);
        `CHK(g1_byte, 8'h00)
        t_signal_loss();
        t_frame();
        t_pointer();
        t_cell();
        t_overhead();
        final_report();
    end
endmodule // sonet_rx_defect_monitor_tb
